// file: shared/eeo_pkg.sv
// package: shared constants and carriers for the encoder emulation output
package eeo_pkg;
	localparam int ANGLE_W = 24;
	localparam int TURNS_W = 12;
	localparam int ANGLE_SER_W = 16;
	localparam int WORD_W = TURNS_W + ANGLE_SER_W;
	localparam int QCNT_W = 21;
	localparam int CLOCK_NS = 50;
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_QUAD = 2'h1;
	localparam logic [1:0] SEL_SERIAL = 2'h2;
	localparam logic [1:0] SEL_INTERP = 2'h3;
	localparam logic [4:0] LINES_MIN_LOG2 = 5'h08;
	localparam logic [4:0] LINES_MAX_RES_LOG2 = 5'h0C;
	localparam logic [4:0] LINES_MAX_ENC_LOG2 = 5'h13;
	localparam logic [2:0] INTERP_MIN_LOG2 = 3'h2;
	localparam logic [2:0] INTERP_MAX_LOG2 = 3'h7;
	localparam logic [QCNT_W-1:0] ZERO_PHASE = 21'h000002;
	localparam int IDLE_SHORT_NS = 1300;
	localparam int IDLE_LONG_NS = 10000;
	localparam int IDLE_SHORT_CYC = (IDLE_SHORT_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int IDLE_LONG_CYC = (IDLE_LONG_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam logic [4:0] BITS_RESET = 5'h00;
	localparam logic [7:0] IDLE_RESET = 8'h00;

	typedef struct packed {
		logic [TURNS_W-1:0] turns;
		logic [ANGLE_W-1:0] angle;
	} eeo_pos_t;

	typedef struct packed {
		logic [1:0] encoder_output_select;
		logic feedback_is_resolver;
		logic [4:0] lines_log2;
		logic [4:0] sine_lines_log2;
		logic [2:0] interp_log2;
		logic [ANGLE_W-1:0] zero_pulse_offset;
		logic serial_code_select;
		logic serial_idle_time_select;
	} eeo_cfg_t;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_SHIFT = 2'b01,
		SER_HOLD = 2'b10
	} eeo_ser_t;
endpackage

// file: hw/eeo_top.sv
// module: encoder emulation, quadrature and synchronous serial absolute output
//
// How it works
// - quadrature mode drives A and B a quarter period apart, plus zero pulse
// - edges follow the internal shaft position continuously, one step per clock
// - lines per revolution 2^8..2^12 with resolver, 2^8..2^19 with encoder
// - output select code 1 chooses plain quadrature emulation
// - code 1 gives one zero pulse per revolution, only while A and B are both high
// - code 3 gives 2^2..2^7 lines per sine period, zero track passed through
// - code 1 zero pulse angle within a turn set by zero_pulse_offset; code 3 takes it from the zero track
// - clockwise rotation makes the emulated count rise in both modes
// - serial mode sends a 28-bit position word per read cycle
// - 12-bit turn count MSB first, then 16-bit angle MSB first
// - serial_code_select picks Gray or binary word coding
// - idle timeout selectable 1.3 us or 10 us; reader matches its clock
`timescale 1ns/100ps
module eeo_top
	import eeo_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire eeo_pkg::eeo_pos_t shaft_pos,
	input wire eeo_pkg::eeo_cfg_t cfg,
	input wire logic zero_track_in,
	input wire logic serial_clk,
	output logic quad_a,
	output logic quad_b,
	output logic quad_zero,
	output logic serial_data,
	output logic serial_busy
);
	// quadrature state
	logic [QCNT_W-1:0] qcnt, next_qcnt;
	logic next_quad_a, next_quad_b, next_quad_zero;
	logic zsync1, zsync2;
	logic [QCNT_W-1:0] target, diff, mod_mask;
	logic [4:0] lines_eff, total_log2;
	logic [2:0] interp_eff;
	logic [ANGLE_W-1:0] angle_off;
	logic quad_on, interp_on, quad_live;

	always_comb begin
		quad_on = cfg.encoder_output_select == SEL_QUAD;
		interp_on = cfg.encoder_output_select == SEL_INTERP;
		quad_live = quad_on || interp_on;
		lines_eff = cfg.lines_log2;
		if (lines_eff < LINES_MIN_LOG2) begin
			lines_eff = LINES_MIN_LOG2;
		end
		if (cfg.feedback_is_resolver && lines_eff > LINES_MAX_RES_LOG2) begin
			lines_eff = LINES_MAX_RES_LOG2;
		end else if (lines_eff > LINES_MAX_ENC_LOG2) begin
			lines_eff = LINES_MAX_ENC_LOG2;
		end
		interp_eff = cfg.interp_log2;
		if (interp_eff < INTERP_MIN_LOG2) begin
			interp_eff = INTERP_MIN_LOG2;
		end else if (interp_eff > INTERP_MAX_LOG2) begin
			interp_eff = INTERP_MAX_LOG2;
		end
		// the sum is clamped so the count never outgrows the counter
		total_log2 = interp_on ? 5'(cfg.sine_lines_log2 + 5'(interp_eff)) : lines_eff;
		if (total_log2 > LINES_MAX_ENC_LOG2) begin
			total_log2 = LINES_MAX_ENC_LOG2;
		end
		angle_off = shaft_pos.angle - cfg.zero_pulse_offset;
		target = QCNT_W'(angle_off >> (5'(ANGLE_W) - total_log2 - 5'h02));
		// the count wraps with the revolution, so a pass through zero takes the short way
		mod_mask = QCNT_W'((22'h000001 << (total_log2 + 5'h02)) - 22'h000001);
		diff = (target - qcnt) & mod_mask;
		next_qcnt = qcnt;
		if (diff != '0) begin
			// one step per clock keeps every edge a clean gray step
			next_qcnt = (diff[total_log2 + 5'h01] ? qcnt - 1'b1 : qcnt + 1'b1) & mod_mask;
		end
		next_quad_a = 1'b0;
		next_quad_b = 1'b0;
		next_quad_zero = 1'b0;
		if (quad_on || interp_on) begin
			next_quad_a = next_qcnt[1] ^ next_qcnt[0];
			next_quad_b = next_qcnt[1];
			next_quad_zero = interp_on ? zsync2 : (next_qcnt == ZERO_PHASE);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			qcnt <= '0;
			quad_a <= 1'b0;
			quad_b <= 1'b0;
			quad_zero <= 1'b0;
			zsync1 <= 1'b0;
			zsync2 <= 1'b0;
		end else begin
			qcnt <= next_qcnt;
			quad_a <= next_quad_a;
			quad_b <= next_quad_b;
			quad_zero <= next_quad_zero;
			zsync1 <= zero_track_in;
			zsync2 <= zsync1;
		end
	end

	// serial state
	eeo_ser_t ser, next_ser;
	logic sc1, sc2, sc3;
	logic [WORD_W-1:0] word, shreg, next_shreg;
	logic [4:0] bits, next_bits;
	logic [7:0] idle, next_idle, idle_lim;
	logic next_serial_data;
	logic sc_fall, sc_rise, ser_on;

	always_comb begin
		ser_on = cfg.encoder_output_select == SEL_SERIAL;
		sc_fall = sc3 && !sc2;
		sc_rise = !sc3 && sc2;
		word = {shaft_pos.turns, shaft_pos.angle[ANGLE_W-1 -: ANGLE_SER_W]};
		if (cfg.serial_code_select) begin
			word = word ^ (word >> 1);
		end
		idle_lim = cfg.serial_idle_time_select ? 8'(IDLE_LONG_CYC) : 8'(IDLE_SHORT_CYC);
		next_ser = ser;
		next_shreg = shreg;
		next_bits = bits;
		next_idle = (sc_fall || sc_rise) ? IDLE_RESET : idle + 8'h01;
		next_serial_data = serial_data;
		case (ser)
			SER_IDLE: begin
				next_idle = IDLE_RESET;
				next_serial_data = 1'b1;
				if (ser_on && sc_fall) begin
					next_shreg = word;
					next_bits = BITS_RESET;
					next_serial_data = 1'b0;
					next_ser = SER_SHIFT;
				end
			end
			SER_SHIFT: begin
				if (sc_rise) begin
					next_serial_data = shreg[WORD_W-1];
					next_shreg = {shreg[WORD_W-2:0], 1'b0};
					next_bits = bits + 5'h01;
					if (bits == 5'(WORD_W - 1)) begin
						next_ser = SER_HOLD;
					end
				end else if (idle >= idle_lim) begin
					next_ser = SER_IDLE;
				end
			end
			SER_HOLD: begin
				// extra rising edges read zero until the line rests
				if (sc_rise) begin
					next_serial_data = 1'b0;
				end
				if (idle >= idle_lim) begin
					next_serial_data = 1'b1;
					next_ser = SER_IDLE;
				end
			end
			default: begin
				next_ser = SER_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ser <= SER_IDLE;
			shreg <= '0;
			bits <= BITS_RESET;
			idle <= IDLE_RESET;
			serial_data <= 1'b1;
			sc1 <= 1'b1;
			sc2 <= 1'b1;
			sc3 <= 1'b1;
		end else begin
			ser <= next_ser;
			shreg <= next_shreg;
			bits <= next_bits;
			idle <= next_idle;
			serial_data <= next_serial_data;
			sc1 <= serial_clk;
			sc2 <= sc1;
			sc3 <= sc2;
		end
	end

	assign serial_busy = ser != SER_IDLE;

	sequence s_latch;
		ser == SER_IDLE && ser_on && sc_fall;
	endsequence

	sequence s_started;
		serial_busy && !serial_data;
	endsequence

	// a mode change may drop A and B together; only steps inside a running mode count
	a_quad_quarter: assert property (@(posedge clock) disable iff (sys_rst)
		($past(quad_live) && $past(quad_live, 2)) |-> !(quad_a != $past(quad_a) && quad_b != $past(quad_b)))
		else $error("A and B changed together");
	a_quad_follow: assert property (@(posedge clock) disable iff (sys_rst)
		(diff != '0) |=> (qcnt != $past(qcnt)))
		else $error("count did not follow position");
	a_lines_range: assert property (@(posedge clock) disable iff (sys_rst)
		lines_eff >= LINES_MIN_LOG2 && (!cfg.feedback_is_resolver || lines_eff <= LINES_MAX_RES_LOG2))
		else $error("line count out of range");
	a_mode_off: assert property (@(posedge clock) disable iff (sys_rst)
		(!quad_on && !interp_on) |=> (!quad_a && !quad_b && !quad_zero))
		else $error("quadrature active in other mode");
	a_zero_ab: assert property (@(posedge clock) disable iff (sys_rst)
		(quad_zero && $past(quad_on)) |-> (quad_a && quad_b && qcnt == ZERO_PHASE))
		else $error("zero pulse without A=B=1");
	a_zero_pass: assert property (@(posedge clock) disable iff (sys_rst)
		interp_on |=> (quad_zero == $past(zsync2)))
		else $error("zero track not passed through");
	a_count_up: assert property (@(posedge clock) disable iff (sys_rst)
		(diff == 21'h000001) |=> (2'(qcnt - $past(qcnt)) == 2'h1))
		else $error("count did not rise");
	a_latch_word: assert property (@(posedge clock) disable iff (sys_rst)
		s_latch |=> s_started ##0 (shreg == $past(word)))
		else $error("word not latched on falling edge");
	a_msb_first: assert property (@(posedge clock) disable iff (sys_rst)
		(ser == SER_SHIFT && sc_rise) |=> (serial_data == $past(shreg[WORD_W-1])))
		else $error("bit order wrong");
	a_gray_code: assert property (@(posedge clock) disable iff (sys_rst)
		(s_latch and cfg.serial_code_select) |=> (shreg[WORD_W-1] == $past(shaft_pos.turns[TURNS_W-1])))
		else $error("gray word top bit wrong");
	a_idle_return: assert property (@(posedge clock) disable iff (sys_rst)
		(ser == SER_HOLD && idle >= idle_lim) |=> (!serial_busy && serial_data))
		else $error("no return to idle after timeout");
	a_word_len: assert property (@(posedge clock) disable iff (sys_rst)
		(ser == SER_SHIFT && sc_rise && bits == 5'(WORD_W - 1)) |=> (ser == SER_HOLD && bits == 5'(WORD_W)))
		else $error("word length not 28");
endmodule

// file: tb/eeo_reader.sv
// partner model: serial position reader
`timescale 1ns/100ps
module eeo_reader (
	input wire logic clock,
	input wire logic start,
	input wire logic serial_data,
	output logic serial_clk,
	output logic [27:0] word,
	output logic done
);
	// half period of 4 clocks, under either timeout; clock stands high between frames
	initial begin
		serial_clk = 1'b1;
		word = '0;
		done = 1'b0;
		forever begin
			do begin
				@(posedge clock);
			end while (start !== 1'b1);
			done <= 1'b0;
			serial_clk <= 1'b0;
			repeat (4) @(posedge clock);
			for (int i = 0; i < 28; i++) begin
				serial_clk <= 1'b1;
				repeat (4) @(posedge clock);
				word <= {word[26:0], serial_data};
				serial_clk <= 1'b0;
				repeat (4) @(posedge clock);
			end
			serial_clk <= 1'b1;
			done <= 1'b1;
		end
	end
endmodule

// file: tb/encoder_emulation_output_test.sv
// testbench: encoder emulation output
`timescale 1ns/100ps
module encoder_emulation_output_test;
	import eeo_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	eeo_pos_t shaft_pos = '0;
	eeo_cfg_t cfg = '0;
	logic zero_track_in = 1'b0;
	logic start = 1'b0;
	logic serial_clk, quad_a, quad_b, quad_zero, serial_data, serial_busy, done;
	logic [27:0] word;
	logic [WORD_W-1:0] exp;
	int failures = 0;
	int checks_done = 0;
	initial forever #25 clock = ~clock;
	eeo_top dut_u (.clock(clock), .sys_rst(sys_rst), .shaft_pos(shaft_pos), .cfg(cfg),
		.zero_track_in(zero_track_in), .serial_clk(serial_clk), .quad_a(quad_a), .quad_b(quad_b),
		.quad_zero(quad_zero), .serial_data(serial_data), .serial_busy(serial_busy));
	eeo_reader rd_u (.clock(clock), .start(start), .serial_data(serial_data), .serial_clk(serial_clk),
		.word(word), .done(done));
	task check_bit(input logic got, input logic want);
		checks_done++;
		if (got !== want) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] want);
		checks_done++;
		if (got !== want) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task do_reset;
		sys_rst <= 1'b1;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		settle(1);
	endtask
	task test_quad;
		@(posedge clock);
		cfg.encoder_output_select <= SEL_QUAD;
		cfg.lines_log2 <= 5'h08;
		for (int k = 1; k <= 4; k++) begin
			@(posedge clock);
			shaft_pos.angle <= 24'(k) << 14;
			settle(3);
			check_bit(quad_a, k == 1 || k == 2);
			check_bit(quad_b, k == 2 || k == 3);
			check_bit(quad_zero, k == 2);
		end
		@(posedge clock);
		cfg.zero_pulse_offset <= 24'h008000;
		settle(4);
		check_bit(quad_zero & quad_a & quad_b, 1'b1);
		@(posedge clock);
		cfg.encoder_output_select <= SEL_OFF;
		settle(2);
		check_bit(quad_a | quad_b | quad_zero, 1'b0);
		$display("test_quad done");
	endtask
	task test_clamp;
		@(posedge clock);
		cfg <= '0;
		shaft_pos <= '0;
		do_reset();
		@(posedge clock);
		cfg.encoder_output_select <= SEL_QUAD;
		cfg.feedback_is_resolver <= 1'b1;
		cfg.lines_log2 <= 5'h1F;
		shaft_pos.angle <= 24'h000400;
		settle(4);
		check_bit(quad_a & ~quad_b, 1'b1);
		$display("test_clamp done");
	endtask
	task test_interp;
		@(posedge clock);
		cfg.encoder_output_select <= SEL_INTERP;
		cfg.sine_lines_log2 <= 5'h08;
		cfg.interp_log2 <= 3'h7;
		shaft_pos.angle <= 24'h000100;
		zero_track_in <= 1'b1;
		settle(5);
		check_bit(quad_zero, 1'b1);
		// 2^8 sine lines times 2^7 gives count 2 here; without interpolation it would stay 0
		check_bit(quad_a & quad_b, 1'b1);
		@(posedge clock);
		zero_track_in <= 1'b0;
		settle(5);
		check_bit(quad_zero, 1'b0);
		$display("test_interp done");
	endtask
	task test_serial(input logic gray, input logic long_idle);
		@(posedge clock);
		cfg.encoder_output_select <= SEL_SERIAL;
		cfg.serial_code_select <= gray;
		cfg.serial_idle_time_select <= long_idle;
		shaft_pos <= {12'hA5C, 24'h3C96F1};
		settle(long_idle ? IDLE_LONG_CYC : IDLE_SHORT_CYC);
		check_bit(serial_data & ~serial_busy & ~quad_a, 1'b1);
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		// done from the last frame only falls on the edge that takes start, so look after it
		@(posedge clock);
		for (int i = 0; i < 600 && done !== 1'b1; i++) @(posedge clock);
		if (done !== 1'b1) begin
			failures++;
			$display("reader did not finish at %0t", $time);
		end
		exp = {12'hA5C, 16'h3C96};
		if (gray) exp = exp ^ (exp >> 1);
		check_word(word, exp);
		settle(40);
		check_bit(serial_busy, long_idle);
		settle(IDLE_LONG_CYC);
		check_bit(serial_data & ~serial_busy, 1'b1);
		$display("test_serial done");
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		$display("watchdog expired");
		stop_test();
	end
	initial begin
		do_reset();
		test_quad();
		test_clamp();
		test_interp();
		test_serial(1'b0, 1'b0);
		test_serial(1'b1, 1'b1);
		stop_test();
	end
endmodule
